// *** rail_voltage_supervisor.sv ***
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Flag warn/fault when sample leaves threshold window
// RQ2 - Fault takes the configured response action
// RQ3 - Values in linear format, per-rail exponent
// RQ4 - Automatic mode always requests turn-on
// RQ5 - Control-line mode follows the control line
// RQ6 - Command mode follows last operation state
// RQ7 - Both mode: on needs line and command
// RQ8 - Both mode: off if either source off
// RQ9 - Enable changes only once conditions qualify
// RQ10 - Adaptive mode accepts setpoint writes anytime
// RQ11 - Adaptive thresholds are fixed setpoint proportions
// RQ12 - Setpoint up: over thresholds jump immediately
// RQ13 - Setpoint up: others rise 20 mV per 400 us
// RQ14 - Setpoint down: under and good thresholds jump
// RQ15 - Setpoint down: over and margin fall stepwise
// RQ16 - Margins always step, either direction
// RQ17 - Power good with on/off hysteresis
// RQ18 - Ignore under-voltage while off or before good
// RQ19 - Final step lands exactly on target
// RQ20 - New setpoint restarts stepping from present values
module rail_voltage_supervisor import rail_supervisor_pkg::*; #(
  parameter int STEP_TICKS = STEP_CYCLES
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [rail_supervisor_pkg::ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [rail_supervisor_pkg::ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [15:0] rail_sense_input, // Sampled rail voltage mantissa
  input wire logic sample_valid, // New sample present
  input wire logic control_line, // Bus control line, high = asserted
  input wire logic turn_qualified, // Dependencies and delays satisfied
  output logic rail_enable, // Rail enable output
  output logic power_good, // Rail power good status
  output logic warn_event, // One-cycle warning pulse
  output logic fault_event // One-cycle fault pulse
);
  import rail_supervisor_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] ctrl;
    logic [4:0] expo;
    logic [15:0] setpt;
    logic [7:0][15:0] ratio;
    logic [7:0][15:0] thr;
    logic [3:0] flags;
    logic pg;
    logic pg_seen;
    logic rail_en;
    logic req;
    logic shut;
    logic stepping;
    logic [15:0] sample;
    logic [15:0] tick_cnt;
    logic warn_evt;
    logic fault_evt;
  } state_t;

  state_t s_q, s_d;

  // Threshold as a fixed fraction of the setpoint
  function automatic logic [15:0] target(input logic [15:0] sp, input logic [15:0] r);
    logic [31:0] p;
    p = sp * r;
    return p[RATIO_FRAC+15:RATIO_FRAC];
  endfunction : target

  // 20 mV in mantissa units; truncates, never below one LSB
  function automatic logic [15:0] step_size(input logic [4:0] e);
    logic [31:0] v;
    int n;
    n = e[4] ? 32 - int'(e) : 0;
    v = 32'(STEP_MV << n) / 32'd1000;
    return (v == 32'h0) ? 16'h0001 : v[15:0];
  endfunction : step_size

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m[i*8+:8] = b[i] ? d[i*8+:8] : o[i*8+:8];
    end
    return m;
  endfunction : merge

  // Word index inside a register group; groups need not start on a 32-byte boundary
  function automatic logic [2:0] word_index(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[4:2];
  endfunction : word_index

  logic do_wr, sp_wr, sp_up, sense_en, adapt;
  logic [31:0] wr_val;
  logic [15:0] step, new_sp;
  logic [3:0] set_f;
  logic [15:0] ovf_new;
  logic [2:0] aw_ratio_idx, ar_ratio_idx, ar_thr_idx;

  always_comb begin
    s_d = s_q;
    s_d.warn_evt = 1'b0;
    s_d.fault_evt = 1'b0;
    sense_en = s_q.ctrl[CTRL_SENSE];
    adapt = s_q.ctrl[CTRL_ADAPT];
    step = step_size(s_q.expo);
    set_f = 4'h0;
    sp_wr = 1'b0;
    sp_up = 1'b0;
    new_sp = s_q.setpt;
    ovf_new = 16'h0000;
    wr_val = 32'h0;
    do_wr = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    aw_ratio_idx = word_index(s_q.aw_addr, OFF_RATIO);
    ar_ratio_idx = word_index(araddr, OFF_RATIO);
    ar_thr_idx = word_index(araddr, OFF_THR);

    if (awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end

    // Threshold stepping; immediate ones already sit on target
    if (!adapt) begin
      for (int i = 0; i < 8; i++) begin
        s_d.thr[i] = target(s_q.setpt, s_q.ratio[i]);
      end
      s_d.stepping = 1'b0;
      s_d.tick_cnt = 16'h0000;
    end else if (s_q.stepping) begin
      if (s_q.tick_cnt == 16'(STEP_TICKS - 1)) begin // RQ13 RQ15 RQ16
        s_d.tick_cnt = 16'h0000;
        s_d.stepping = 1'b0;
        for (int i = 0; i < 8; i++) begin
          if (s_q.thr[i] > target(s_q.setpt, s_q.ratio[i])) begin
            if (s_q.thr[i] - target(s_q.setpt, s_q.ratio[i]) <= step) begin
              s_d.thr[i] = target(s_q.setpt, s_q.ratio[i]); // RQ19
            end else begin
              s_d.thr[i] = s_q.thr[i] - step; // RQ15
              s_d.stepping = 1'b1;
            end
          end else if (s_q.thr[i] < target(s_q.setpt, s_q.ratio[i])) begin
            if (target(s_q.setpt, s_q.ratio[i]) - s_q.thr[i] <= step) begin
              s_d.thr[i] = target(s_q.setpt, s_q.ratio[i]); // RQ19
            end else begin
              s_d.thr[i] = s_q.thr[i] + step; // RQ13
              s_d.stepping = 1'b1;
            end
          end
        end
      end else begin
        s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
      end
    end

    if (do_wr) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (s_q.aw_addr == OFF_CTRL) begin
        wr_val = merge({24'h0, s_q.ctrl}, s_q.w_data, s_q.w_strb);
        s_d.ctrl = wr_val[7:0];
      end else if (s_q.aw_addr == OFF_EXPON) begin
        wr_val = merge({27'h0, s_q.expo}, s_q.w_data, s_q.w_strb);
        s_d.expo = wr_val[4:0]; // RQ3
      end else if (s_q.aw_addr == OFF_SETPT) begin
        wr_val = merge({16'h0, s_q.setpt}, s_q.w_data, s_q.w_strb);
        new_sp = wr_val[15:0];
        sp_wr = 1'b1;
      end else if (s_q.aw_addr == OFF_STATUS) begin
        s_d.flags = s_q.flags & ~s_q.w_data[3:0];
      end else if (s_q.aw_addr >= OFF_RATIO && s_q.aw_addr < OFF_THR &&
                   s_q.aw_addr[1:0] == 2'b00) begin
        wr_val = merge({16'h0, s_q.ratio[aw_ratio_idx]}, s_q.w_data, s_q.w_strb);
        s_d.ratio[aw_ratio_idx] = wr_val[15:0]; // RQ11
      end else if (!(s_q.aw_addr >= OFF_THR && s_q.aw_addr <= OFF_SAMPLE &&
                     s_q.aw_addr[1:0] == 2'b00)) begin
        s_d.bresp = RESP_SLVERR;
      end
    end

    // New setpoint: one group jumps, the rest restart stepping from where they are
    if (sp_wr) begin
      s_d.setpt = new_sp; // RQ10
      sp_up = new_sp > s_q.setpt;
      ovf_new = target(new_sp, s_q.ratio[TH_OVF]);
      if (adapt && new_sp != s_q.setpt) begin
        s_d.stepping = 1'b1; // RQ20
        s_d.tick_cnt = 16'h0000;
        if (sp_up) begin
          s_d.thr[TH_OVF] = ovf_new; // RQ12
          s_d.thr[TH_OVW] = target(new_sp, s_q.ratio[TH_OVW]); // RQ12
        end else begin
          for (int i = TH_UVW; i <= TH_PGOFF; i++) begin
            s_d.thr[i] = target(new_sp, s_q.ratio[i]); // RQ14
          end
        end
      end
    end

    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h0;
      if (araddr == OFF_CTRL) begin
        s_d.rdata = {24'h0, s_q.ctrl};
      end else if (araddr == OFF_EXPON) begin
        s_d.rdata = {27'h0, s_q.expo};
      end else if (araddr == OFF_SETPT) begin
        s_d.rdata = {16'h0, s_q.setpt};
      end else if (araddr == OFF_STATUS) begin
        s_d.rdata = {23'h0, s_q.shut, s_q.stepping, s_q.req, s_q.rail_en, s_q.pg,
                     s_q.flags};
      end else if (araddr >= OFF_RATIO && araddr < OFF_THR && araddr[1:0] == 2'b00) begin
        s_d.rdata = {16'h0, s_q.ratio[ar_ratio_idx]};
      end else if (araddr >= OFF_THR && araddr < OFF_SAMPLE && araddr[1:0] == 2'b00) begin
        s_d.rdata = {16'h0, s_q.thr[ar_thr_idx]};
      end else if (araddr == OFF_SAMPLE) begin
        s_d.rdata = {16'h0, s_q.sample};
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
    end else if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end

    // Window checks on each sample
    if (sample_valid) begin
      s_d.sample = rail_sense_input;
      if (sense_en) begin
        set_f[ST_OVF] = rail_sense_input > s_q.thr[TH_OVF]; // RQ1
        set_f[ST_OVW] = rail_sense_input > s_q.thr[TH_OVW]; // RQ1
        if (s_q.rail_en && s_q.pg_seen) begin // RQ18
          set_f[ST_UVW] = rail_sense_input < s_q.thr[TH_UVW]; // RQ1
          set_f[ST_UVF] = rail_sense_input < s_q.thr[TH_UVF]; // RQ1
        end
        if (rail_sense_input > s_q.thr[TH_PGON]) begin
          s_d.pg = 1'b1; // RQ17
        end else if (rail_sense_input < s_q.thr[TH_PGOFF]) begin
          s_d.pg = 1'b0; // RQ17
        end
      end
    end
    if (!sense_en) begin
      s_d.pg = s_q.rail_en;
    end
    // Set beats a same-cycle clear
    s_d.flags = s_d.flags | set_f;
    s_d.warn_evt = set_f[ST_OVW] | set_f[ST_UVW];
    s_d.fault_evt = set_f[ST_OVF] | set_f[ST_UVF];

    // Shutdown holds until software clears the fault flags
    s_d.shut = (s_q.shut || (s_d.fault_evt && s_q.ctrl[CTRL_RESP+:2] == RESP_SHUTDOWN)) &&
               (s_d.flags[ST_OVF] || s_d.flags[ST_UVF]); // RQ2

    case (s_q.ctrl[CTRL_ONOFF+:2])
      ONOFF_AUTO: s_d.req = 1'b1; // RQ4
      ONOFF_CTRL: s_d.req = control_line; // RQ5
      ONOFF_OPER: s_d.req = s_q.ctrl[CTRL_OPER]; // RQ6
      default: s_d.req = control_line && s_q.ctrl[CTRL_OPER]; // RQ7 RQ8
    endcase

    if (s_d.shut) begin
      s_d.rail_en = 1'b0; // RQ2
    end else if (turn_qualified) begin
      s_d.rail_en = s_q.req; // RQ9
    end
    if (!s_q.rail_en) begin
      s_d.pg_seen = 1'b0;
    end else if (s_q.pg) begin
      s_d.pg_seen = 1'b1;
    end

    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.ratio <= RATIO_RST;
      s_q.expo <= EXP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign arready = s_q.arready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rresp = s_q.rresp;
  assign rdata = s_q.rdata;
  assign rail_enable = s_q.rail_en;
  assign power_good = s_q.pg;
  assign warn_event = s_q.warn_evt;
  assign fault_event = s_q.fault_evt;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ov_sample;
    sample_valid && s_q.ctrl[CTRL_SENSE] && rail_sense_input > s_q.thr[TH_OVF];
  endsequence
  property p_ov_fault;
    s_ov_sample |=> (fault_event && s_q.flags[ST_OVF]) ##1 (!fault_event || $past(sample_valid));
  endproperty
  a_ov_fault: assert property (p_ov_fault) else $error("over fault not flagged"); // RQ1
  property p_resp_shut;
    s_ov_sample and (s_q.ctrl[CTRL_RESP+:2] == RESP_SHUTDOWN) |=> !rail_enable && s_q.shut;
  endproperty
  a_resp_shut: assert property (p_resp_shut) else $error("fault did not shut rail"); // RQ2
  property p_auto;
    s_q.ctrl[CTRL_ONOFF+:2] == ONOFF_AUTO |=> s_q.req;
  endproperty
  a_auto: assert property (p_auto) else $error("auto mode not requesting"); // RQ4
  property p_ctrl_only;
    s_q.ctrl[CTRL_ONOFF+:2] == ONOFF_CTRL |=> s_q.req == $past(control_line);
  endproperty
  a_ctrl_only: assert property (p_ctrl_only) else $error("request not line"); // RQ5
  property p_oper_only;
    s_q.ctrl[CTRL_ONOFF+:2] == ONOFF_OPER |=> s_q.req == $past(s_q.ctrl[CTRL_OPER]);
  endproperty
  a_oper_only: assert property (p_oper_only) else $error("request not command"); // RQ6
  property p_both_off;
    s_q.ctrl[CTRL_ONOFF+:2] == ONOFF_BOTH && !(control_line && s_q.ctrl[CTRL_OPER])
      |=> !s_q.req;
  endproperty
  a_both_off: assert property (p_both_off) else $error("both mode not off"); // RQ8
  property p_hold_unqual;
    !turn_qualified && !s_d.shut |=> $stable(rail_enable);
  endproperty
  a_hold_unqual: assert property (p_hold_unqual) else $error("enable moved unqualified"); // RQ9
  property p_ov_jump;
    sp_wr && adapt && sp_up |=> s_q.thr[TH_OVF] == $past(ovf_new);
  endproperty
  a_ov_jump: assert property (p_ov_jump) else $error("over threshold not immediate"); // RQ12
  property p_pg_hold;
    sample_valid && s_q.ctrl[CTRL_SENSE] && rail_sense_input <= s_q.thr[TH_PGON] &&
      rail_sense_input >= s_q.thr[TH_PGOFF] |=> power_good == $past(power_good);
  endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("power good moved in band"); // RQ17
  property p_uv_off;
    sample_valid && !s_q.rail_en |=> !s_q.flags[ST_UVF] || $past(s_q.flags[ST_UVF]);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("under fault while off"); // RQ18
endmodule : rail_voltage_supervisor

// *** rail_supervisor_pkg.sv ***
package rail_supervisor_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EXPON = 8'h04;
  localparam logic [7:0] OFF_SETPT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RATIO = 8'h10;
  localparam logic [7:0] OFF_THR = 8'h30;
  localparam logic [7:0] OFF_SAMPLE = 8'h50;
  localparam int CTRL_SENSE = 0;
  localparam int CTRL_ADAPT = 1;
  localparam int CTRL_ONOFF = 2;
  localparam int CTRL_OPER = 4;
  localparam int CTRL_RESP = 5;
  localparam logic [1:0] ONOFF_AUTO = 2'h0;
  localparam logic [1:0] ONOFF_CTRL = 2'h1;
  localparam logic [1:0] ONOFF_OPER = 2'h2;
  localparam logic [1:0] ONOFF_BOTH = 2'h3;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h1;
  localparam int ST_OVF = 0;
  localparam int ST_OVW = 1;
  localparam int ST_UVW = 2;
  localparam int ST_UVF = 3;
  localparam int ST_PG = 4;
  localparam int ST_EN = 5;
  localparam int ST_REQ = 6;
  localparam int ST_STEP = 7;
  localparam int ST_SHUT = 8;
  localparam int TH_OVF = 0;
  localparam int TH_OVW = 1;
  localparam int TH_MH = 2;
  localparam int TH_ML = 3;
  localparam int TH_UVW = 4;
  localparam int TH_UVF = 5;
  localparam int TH_PGON = 6;
  localparam int TH_PGOFF = 7;
  localparam int RATIO_FRAC = 10;
  localparam logic [7:0][15:0] RATIO_RST = {16'h0366, 16'h039A, 16'h0366, 16'h039A,
                                            16'h03CD, 16'h0433, 16'h0466, 16'h049A};
  localparam logic [4:0] EXP_RST = 5'h13;
  localparam int STEP_MV = 20;
  localparam int STEP_US = 400;
  localparam int CLK_MHZ = 50;
  localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rail_supervisor_pkg

// *** rail_supply_model.sv ***
`timescale 1ns/1ps
module rail_supply_model #(
  parameter int SAMPLE_DIV = 4
) (
  input wire logic aclk, // System clock
  input wire logic rail_enable, // Enable from the supervisor
  input wire logic [15:0] level, // Voltage the rail settles to when on
  output logic [15:0] rail_sense_input, // Converted rail voltage
  output logic sample_valid // Conversion done strobe
);
  int div_q = 0;

  initial begin
    rail_sense_input = 16'h0000;
    sample_valid = 1'b0;
  end

  // A rail that is switched off reads zero, so stale levels never reach the monitor
  always @(posedge aclk) begin
    div_q <= (div_q == SAMPLE_DIV - 1) ? 0 : div_q + 1;
    sample_valid <= (div_q == SAMPLE_DIV - 1);
    rail_sense_input <= rail_enable ? level : 16'h0000;
  end
endmodule : rail_supply_model

// *** test_rail_voltage_supervisor.sv ***
`timescale 1ns/1ps
module test_rail_voltage_supervisor;
  import rail_supervisor_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  // Ready for every response at any time, so a task never has to drop them
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] sense;
  logic [15:0] level = 16'h3000;
  logic sample_valid, rail_enable, power_good, warn_event, fault_event;
  logic control_line = 1'b0;
  logic turn_qualified = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;
  int n_fault_ev = 0;
  int n_warn_ev = 0;
  int f0;
  logic [31:0] rd;
  logic [1:0] rsp;

  always #10 aclk = ~aclk;

  rail_voltage_supervisor #(.STEP_TICKS(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rail_sense_input(sense), .sample_valid(sample_valid),
    .control_line(control_line), .turn_qualified(turn_qualified),
    .rail_enable(rail_enable), .power_good(power_good),
    .warn_event(warn_event), .fault_event(fault_event)
  );

  rail_supply_model #(.SAMPLE_DIV(4)) i_supply (
    .aclk(aclk), .rail_enable(rail_enable), .level(level),
    .rail_sense_input(sense), .sample_valid(sample_valid)
  );

  always @(posedge aclk) begin
    if (fault_event === 1'b1) n_fault_ev++;
    if (warn_event === 1'b1) n_warn_ev++;
  end

  task automatic report_and_stop();
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 50) begin
      n_fail++;
      report_and_stop();
    end
  endtask : tick

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    logic ta = 1'b0;
    logic tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      tick(n);
      if (!ta && awready === 1'b1) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do tick(n); while (bvalid !== 1'b1);
    r = bresp;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do tick(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do tick(n); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rsp);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    axi_read(a, rd, rsp);
    check(nm, e, rd);
  endtask : rd_chk

  task automatic flags(input string nm, input logic [31:0] e);
    axi_read(OFF_STATUS, rd, rsp);
    check(nm, e, rd & 32'h0000000F);
  endtask : flags

  function automatic logic [31:0] thr(input logic [15:0] sp, input int i);
    return (32'(sp) * 32'(RATIO_RST[i])) >> 10;
  endfunction : thr

  function automatic logic [7:0] ta(input int i);
    return OFF_THR + 8'(4 * i);
  endfunction : ta

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("ctrl_rst", OFF_CTRL, 32'h00000000);
    rd_chk("expon_rst", OFF_EXPON, 32'h00000013);
    rd_chk("ratio_rst", OFF_RATIO, 32'h0000049A);
    axi_read(8'hFC, rd, rsp);
    check("unmapped_rresp", 32'(RESP_SLVERR), 32'(rsp));
    axi_write(8'hFC, 32'h00000001, rsp);
    check("unmapped_bresp", 32'(RESP_SLVERR), 32'(rsp));
    wr(OFF_THR, 32'h0000FFFF);
    rd_chk("thr_read_only", OFF_THR, 32'h00000000);
    repeat (5) @(posedge aclk);
    check("en_unqualified", 32'h0, 32'(rail_enable));
    turn_qualified <= 1'b1;
    repeat (4) @(posedge aclk);
    check("en_auto", 32'h1, 32'(rail_enable));
    // Control-line, command and both on/off sources against every line and command combination
    for (int c = 1; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        control_line <= k[0];
        wr(OFF_CTRL, 32'((c << 2) | (k[1] << 4)));
        repeat (4) @(posedge aclk);
        check("en_onoff", 32'(c == 1 ? k[0] : (c == 2 ? k[1] : k[0] & k[1])),
              32'(rail_enable));
      end
    end
    control_line <= 1'b0;
    // Thresholds first: sensing against zero thresholds would flag over faults at once
    wr(OFF_SETPT, 32'h00003000);
    wr(OFF_CTRL, 32'h00000005);
    for (int i = 0; i < 8; i++) rd_chk("thr_fixed", ta(i), thr(16'h3000, i));
    repeat (12) @(posedge aclk);
    flags("flags_rail_off", 32'h0);
    control_line <= 1'b1;
    repeat (12) @(posedge aclk);
    check("pg_on", 32'h1, 32'(power_good));
    flags("flags_startup", 32'h0);
    level <= 16'h2A30;
    repeat (12) @(posedge aclk);
    check("pg_hold", 32'h1, 32'(power_good));
    level <= 16'h2710;
    repeat (12) @(posedge aclk);
    check("pg_off", 32'h0, 32'(power_good));
    flags("flags_under", 32'hC);
    check("warn_ev", 32'h1, 32'(n_warn_ev > 0));
    // Restore the level first, or samples still below the window re-set the flags
    level <= 16'h3000;
    repeat (8) @(posedge aclk);
    wr(OFF_STATUS, 32'h0000000F);
    flags("flags_clear", 32'h0);
    wr(OFF_CTRL, 32'h00000007);
    wr(OFF_SETPT, 32'h00003200);
    rd_chk("ovf_up_now", ta(TH_OVF), thr(16'h3200, TH_OVF));
    axi_read(ta(TH_UVF), rd, rsp);
    check("uvf_up_lags", 32'h1, 32'(rd < thr(16'h3200, TH_UVF)));
    repeat (40) @(posedge aclk);
    rd_chk("uvf_up_done", ta(TH_UVF), thr(16'h3200, TH_UVF));
    rd_chk("mh_up_done", ta(TH_MH), thr(16'h3200, TH_MH));
    wr(OFF_SETPT, 32'h00003000);
    rd_chk("uvf_down_now", ta(TH_UVF), thr(16'h3000, TH_UVF));
    rd_chk("pgon_down_now", ta(TH_PGON), thr(16'h3000, TH_PGON));
    axi_read(ta(TH_OVF), rd, rsp);
    check("ovf_down_lags", 32'h1, 32'(rd > thr(16'h3000, TH_OVF)));
    repeat (40) @(posedge aclk);
    rd_chk("ovf_down_done", ta(TH_OVF), thr(16'h3000, TH_OVF));
    wr(OFF_SETPT, 32'h00003200);
    // Let the margins take one step up, so the restart has to bring them back
    repeat (12) @(posedge aclk);
    wr(OFF_SETPT, 32'h00003000);
    repeat (40) @(posedge aclk);
    rd_chk("mh_restart", ta(TH_MH), thr(16'h3000, TH_MH));
    rd_chk("ml_restart", ta(TH_ML), thr(16'h3000, TH_ML));
    wr(OFF_CTRL, 32'h00000027);
    f0 = n_fault_ev;
    level <= 16'h3A98;
    repeat (12) @(posedge aclk);
    check("fault_ev", 32'h1, 32'(n_fault_ev > f0));
    check("en_shutdown", 32'h0, 32'(rail_enable));
    flags("flags_over", 32'h3);
    report_and_stop();
  end
endmodule : test_rail_voltage_supervisor
